/* fce_engine.sv */
// Error correction and check-value engine of a synchronous NOR flash.
// Assumes the host interface decodes bus commands into one-cycle pulses and
// that the array returns check bits and the reprogram marker with each fetch.
`default_nettype none

module fce_engine (
   input  wire logic                           ref_clk,
   input  wire logic                           rst,
   input  wire logic                           ded_mode_en,
   input  wire logic                           prog_commit,
   input  wire logic [fce_pkg::HP_BITS-1:0]    prog_data,
   input  wire logic                           prog_hp_written,
   output logic                                arr_prog_en_q,
   output logic                                hid_check_we_q,
   output logic      [fce_pkg::CHK_W-1:0]      hid_check_q,
   output logic                                hid_ecc_off_q,
   input  wire logic                           fetch_valid,
   input  wire logic [fce_pkg::HP_ADDR_W-1:0]  fetch_hp_addr,
   input  wire logic [fce_pkg::HP_BITS-1:0]    fetch_data,
   input  wire logic [fce_pkg::CHK_W-1:0]      fetch_check,
   input  wire logic                           fetch_ecc_off,
   input  wire logic [2:0]                     fetch_word_sel,
   output logic                                rd_word_valid_q,
   output logic      [15:0]                    rd_word_q,
   input  wire logic                           ecc_int_en,
   input  wire logic                           strobe_stop_en,
   input  wire logic                           ecc_status_clr,
   input  wire logic                           xfer_end,
   output logic      [1:0]                     ecc_status_q,
   output logic                                ecc_int_q,
   output logic                                read_data_strobe_hold_q,
   output logic      [fce_pkg::ADDR_W-1:0]     ecc_err_addr_q,
   output logic      [fce_pkg::CNT_W-1:0]      ecc_count_q,
   input  wire logic                           dev_standby,
   input  wire logic                           other_aso_active,
   input  wire logic                           cmd_aso_enter,
   input  wire logic                           cmd_aso_exit,
   input  wire logic                           cmd_start_wr,
   input  wire logic                           cmd_end_wr,
   input  wire logic [fce_pkg::ADDR_W-1:0]     cmd_wdata,
   input  wire logic                           cmd_suspend,
   input  wire logic                           cmd_resume,
   input  wire logic                           status_clr,
   output logic                                crc_rd_req_q,
   output logic      [fce_pkg::ADDR_W-1:0]     crc_rd_addr_q,
   input  wire logic                           crc_rd_valid,
   input  wire logic [15:0]                    crc_rd_data,
   input  wire logic                           ovl_rd,
   input  wire logic [fce_pkg::ADDR_W-1:0]     ovl_rd_addr,
   output logic      [15:0]                    ovl_rd_data_q,
   output logic                                address_space_overlay_q,
   output logic      [15:0]                    status_word_q
);

   logic [fce_pkg::CHK_W-1:0]   enc_check;
   logic [fce_pkg::HP_BITS-1:0] fix_data;
   logic                        dec_single;
   logic                        dec_double;
   logic                        ecc_on;
   logic [31:0]                 crc_nx;

   // Encoder: check bits travel only to the hidden storage port.
   fce_hamming u_enc (
      .data       (prog_data),
      .check_in   ('0),
      .ded_en     (1'b0),
      .fix_en     (1'b0),
      .check_out  (enc_check),
      .data_fix   (),
      .single_err (),
      .double_err ()
   );

   assign ecc_on = fetch_valid && !fetch_ecc_off;

   fce_hamming u_dec (
      .data       (fetch_data),
      .check_in   (fetch_check),
      .ded_en     (ded_mode_en),
      .fix_en     (!fetch_ecc_off),
      .check_out  (),
      .data_fix   (fix_data),
      .single_err (dec_single),
      .double_err (dec_double)
   );

   logic ev_corr;
   logic ev_uncorr;
   assign ev_corr   = ecc_on && dec_single;
   assign ev_uncorr = ecc_on && dec_double;

   // Program, fetch and error reporting group.
   logic                       arr_prog_en_d;
   logic                       hid_check_we_d;
   logic [fce_pkg::CHK_W-1:0]  hid_check_d;
   logic                       hid_ecc_off_d;
   logic                       prog_fail_q;
   logic                       prog_fail_d;
   logic                       rd_word_valid_d;
   logic [15:0]                rd_word_d;
   logic [1:0]                 ecc_status_d;
   logic                       ecc_int_d;
   logic                       hold_d;
   logic [fce_pkg::ADDR_W-1:0] ecc_err_addr_d;
   logic [fce_pkg::CNT_W-1:0]  ecc_count_d;

   always_comb begin
      arr_prog_en_d  = 1'b0;
      hid_check_we_d = 1'b0;
      hid_check_d    = hid_check_q;
      hid_ecc_off_d  = hid_ecc_off_q;
      prog_fail_d    = prog_fail_q && !status_clr;
      if (prog_commit) begin
         if (prog_hp_written && ded_mode_en) begin
            prog_fail_d = 1'b1;
         end else begin
            arr_prog_en_d  = 1'b1;
            hid_check_we_d = 1'b1;
            hid_check_d    = enc_check;
            hid_ecc_off_d  = prog_hp_written;
         end
      end
      rd_word_valid_d = fetch_valid;
      rd_word_d = fetch_valid ? fix_data[16*fetch_word_sel +: 16] : rd_word_q;
      // A new event wins over a clear arriving in the same cycle.
      ecc_status_d = ecc_status_clr ? 2'b00 : ecc_status_q;
      ecc_status_d[fce_pkg::ES_CORR]   = ecc_status_d[fce_pkg::ES_CORR] | ev_corr;
      ecc_status_d[fce_pkg::ES_UNCORR] = ecc_status_d[fce_pkg::ES_UNCORR] | ev_uncorr;
      ecc_int_d = ecc_int_en && (ecc_status_d != 2'b00);
      hold_d = (read_data_strobe_hold_q && !xfer_end) || (ev_uncorr && strobe_stop_en);
      ecc_err_addr_d = ecc_err_addr_q;
      ecc_count_d    = ecc_count_q;
      if (ev_corr || ev_uncorr) begin
         ecc_err_addr_d = {fetch_hp_addr, fetch_word_sel};
         if (ecc_count_q != fce_pkg::ECC_CNT_MAX) begin
            ecc_count_d = ecc_count_q + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arr_prog_en_q           <= 1'b0;
         hid_check_we_q          <= 1'b0;
         hid_check_q             <= '0;
         hid_ecc_off_q           <= 1'b0;
         prog_fail_q             <= 1'b0;
         rd_word_valid_q         <= 1'b0;
         rd_word_q               <= 16'h0000;
         ecc_status_q            <= 2'b00;
         ecc_int_q               <= 1'b0;
         read_data_strobe_hold_q <= 1'b0;
         ecc_err_addr_q          <= '0;
         ecc_count_q             <= '0;
      end else begin
         arr_prog_en_q           <= arr_prog_en_d;
         hid_check_we_q          <= hid_check_we_d;
         hid_check_q             <= hid_check_d;
         hid_ecc_off_q           <= hid_ecc_off_d;
         prog_fail_q             <= prog_fail_d;
         rd_word_valid_q         <= rd_word_valid_d;
         rd_word_q               <= rd_word_d;
         ecc_status_q            <= ecc_status_d;
         ecc_int_q               <= ecc_int_d;
         read_data_strobe_hold_q <= hold_d;
         ecc_err_addr_q          <= ecc_err_addr_d;
         ecc_count_q             <= ecc_count_d;
      end
   end

   // Check-value group.
   fce_pkg::fce_crc_state_t    st_q, st_d;
   logic [fce_pkg::ADDR_W-1:0] sa_q, sa_d, ea_q, ea_d, cur_q, cur_d;
   logic [31:0]                crc_q, crc_d;
   logic [15:0]                res_lo_q, res_lo_d, res_hi_q, res_hi_d;
   logic                       ovl_d, abort_q, abort_d, spend_q, spend_d;
   logic                       rd_req_d;
   logic [fce_pkg::ADDR_W-1:0] rd_addr_d;
   logic [15:0]                ovl_data_d;
   logic [15:0]                status_d;
   logic                       start_ok;
   logic                       too_short;

   fce_crc_word u_crc (
      .crc_in  (crc_q),
      .word    (crc_rd_data),
      .crc_out (crc_nx)
   );

   assign start_ok = address_space_overlay_q && cmd_end_wr && st_q == fce_pkg::CRC_IDLE
                     && dev_standby && !other_aso_active;
   assign too_short = {1'b0, cmd_wdata} < ({1'b0, sa_q} + fce_pkg::CRC_MIN_SPAN);

   always_comb begin
      st_d      = st_q;
      sa_d      = sa_q;
      ea_d      = ea_q;
      cur_d     = cur_q;
      crc_d     = crc_q;
      res_lo_d  = res_lo_q;
      res_hi_d  = res_hi_q;
      ovl_d     = address_space_overlay_q;
      abort_d   = abort_q && !status_clr;
      spend_d   = spend_q;
      rd_req_d  = 1'b0;
      rd_addr_d = crc_rd_addr_q;
      if (cmd_aso_enter && !other_aso_active && st_q == fce_pkg::CRC_IDLE) ovl_d = 1'b1;
      if (address_space_overlay_q && cmd_start_wr && st_q == fce_pkg::CRC_IDLE) begin
         sa_d = cmd_wdata;
      end
      if (address_space_overlay_q && cmd_end_wr && st_q == fce_pkg::CRC_IDLE) begin
         ea_d = cmd_wdata;
      end
      if (start_ok) begin
         res_lo_d = fce_pkg::RESULT_RST;
         res_hi_d = fce_pkg::RESULT_RST;
         if (too_short) begin
            abort_d = 1'b1;
         end else begin
            abort_d = 1'b0;
            spend_d = 1'b0;
            cur_d   = sa_q;
            crc_d   = fce_pkg::CRC_INIT;
            st_d    = fce_pkg::CRC_REQ;
         end
      end
      case (st_q)
         fce_pkg::CRC_REQ: begin
            if (spend_q || cmd_suspend) begin
               st_d    = fce_pkg::CRC_SUSP;
               spend_d = 1'b0;
            end else begin
               rd_req_d  = 1'b1;
               rd_addr_d = cur_q;
               st_d      = fce_pkg::CRC_WAIT;
            end
         end
         fce_pkg::CRC_WAIT: begin
            if (cmd_suspend) spend_d = 1'b1;
            if (crc_rd_valid) begin
               crc_d = crc_nx;
               if (cur_q == ea_q) begin
                  {res_hi_d, res_lo_d} = crc_nx ^ fce_pkg::CRC_XOROUT;
                  st_d    = fce_pkg::CRC_IDLE;
                  spend_d = 1'b0;
               end else begin
                  cur_d = cur_q + 1'b1;
                  st_d  = fce_pkg::CRC_REQ;
               end
            end
         end
         fce_pkg::CRC_SUSP: begin
            if (cmd_resume) st_d = fce_pkg::CRC_REQ;
         end
         default: ;
      endcase
      // Exit abandons a running calculation; the results then keep the RESULT_RST value loaded at its start unless the last word arrives in that cycle.
      if (cmd_aso_exit) begin
         ovl_d   = 1'b0;
         st_d    = fce_pkg::CRC_IDLE;
         spend_d = 1'b0;
         rd_req_d = 1'b0;
      end
      ovl_data_d = 16'h0000;
      if (address_space_overlay_q && ovl_rd) begin
         if (ovl_rd_addr == fce_pkg::OVL_RES_LO) ovl_data_d = res_lo_q;
         else if (ovl_rd_addr == fce_pkg::OVL_RES_HI) ovl_data_d = res_hi_q;
      end
      status_d = 16'h0000;
      status_d[fce_pkg::SW_READY]     = st_q == fce_pkg::CRC_IDLE;
      status_d[fce_pkg::SW_CRC_SUSP]  = st_q == fce_pkg::CRC_SUSP;
      status_d[fce_pkg::SW_CRC_ABORT] = abort_q;
      status_d[fce_pkg::SW_PROG_FAIL] = prog_fail_q;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_q                    <= fce_pkg::CRC_IDLE;
         sa_q                    <= '0;
         ea_q                    <= '0;
         cur_q                   <= '0;
         crc_q                   <= 32'h00000000;
         res_lo_q                <= fce_pkg::RESULT_RST;
         res_hi_q                <= fce_pkg::RESULT_RST;
         address_space_overlay_q <= 1'b0;
         abort_q                 <= 1'b0;
         spend_q                 <= 1'b0;
         crc_rd_req_q            <= 1'b0;
         crc_rd_addr_q           <= '0;
         ovl_rd_data_q           <= 16'h0000;
         status_word_q           <= 16'h0000;
      end else begin
         st_q                    <= st_d;
         sa_q                    <= sa_d;
         ea_q                    <= ea_d;
         cur_q                   <= cur_d;
         crc_q                   <= crc_d;
         res_lo_q                <= res_lo_d;
         res_hi_q                <= res_hi_d;
         address_space_overlay_q <= ovl_d;
         abort_q                 <= abort_d;
         spend_q                 <= spend_d;
         crc_rd_req_q            <= rd_req_d;
         crc_rd_addr_q           <= rd_addr_d;
         ovl_rd_data_q           <= ovl_data_d;
         status_word_q           <= status_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   AST_FIRST_PROG: assert property (prog_commit && !prog_hp_written |=>
      hid_check_we_q && arr_prog_en_q && !hid_ecc_off_q) else $error("first program lost");
   AST_REPROG_OFF: assert property (prog_commit && prog_hp_written && !ded_mode_en |=>
      hid_check_we_q && hid_ecc_off_q) else $error("reprogram kept protection");
   AST_DED_REJECT: assert property (prog_commit && prog_hp_written && ded_mode_en |=>
      !arr_prog_en_q && !hid_check_we_q ##1 status_word_q[fce_pkg::SW_PROG_FAIL])
      else $error("double-error mode reprogram not refused");
   AST_STALL: assert property (ev_uncorr && strobe_stop_en |=>
      read_data_strobe_hold_q && ecc_status_q[fce_pkg::ES_UNCORR]) else $error("no stall");
   AST_ERR_ADDR: assert property (ev_corr |=>
      ecc_err_addr_q == $past({fetch_hp_addr, fetch_word_sel})) else $error("address lost");
   AST_COUNT: assert property ((ev_corr || ev_uncorr) &&
      ecc_count_q != fce_pkg::ECC_CNT_MAX |=> ecc_count_q == $past(ecc_count_q) + 1'b1)
      else $error("count missed");
   AST_CLEAR_START: assert property (start_ok |=>
      res_lo_q == fce_pkg::RESULT_RST && res_hi_q == fce_pkg::RESULT_RST)
      else $error("results not cleared");
   AST_ABORT: assert property (start_ok && too_short |=>
      st_q == fce_pkg::CRC_IDLE ##1 status_word_q[fce_pkg::SW_CRC_ABORT] &&
      status_word_q[fce_pkg::SW_READY]) else $error("short range not aborted");
   AST_BUSY: assert property (st_q != fce_pkg::CRC_IDLE |=>
      !status_word_q[fce_pkg::SW_READY]) else $error("ready while busy");
   AST_SUSP: assert property (st_q == fce_pkg::CRC_SUSP |=>
      status_word_q[fce_pkg::SW_CRC_SUSP] && !crc_rd_req_q) else $error("suspend not shown");
   AST_OVL_LO: assert property (address_space_overlay_q && ovl_rd &&
      ovl_rd_addr == fce_pkg::OVL_RES_LO |=> ovl_rd_data_q == $past(res_lo_q))
      else $error("low result read wrong");
   AST_EXIT: assert property (cmd_aso_exit |=>
      !address_space_overlay_q && st_q == fce_pkg::CRC_IDLE) else $error("exit ignored");

   COV_DED_REJECT: cover property (prog_commit && prog_hp_written && ded_mode_en);
   COV_CRC_DONE:   cover property (st_q == fce_pkg::CRC_WAIT && crc_rd_valid && cur_q == ea_q);
   COV_SUSPEND:    cover property (st_q == fce_pkg::CRC_SUSP ##1 cmd_resume);
   COV_UNCORR:     cover property (ev_uncorr && strobe_stop_en);

endmodule // fce_engine
`default_nettype wire

/* fce_pkg.sv */
// Constants, state codes and helpers shared by the flash integrity engine.
// Assumes word addressing: one address selects one 16-bit array word.
`default_nettype none

package fce_pkg;

   localparam int ADDR_W   = 25;
   localparam int HP_ADDR_W = ADDR_W - 3;
   localparam int HP_BITS  = 128;
   localparam int SYN_W    = 8;
   localparam int CHK_W    = SYN_W + 1;
   localparam int CNT_W    = 16;

   localparam logic [CNT_W-1:0]  ECC_CNT_MAX = 16'hFFFF;
   localparam logic [31:0]       CRC_POLY    = 32'h1EDC6F41;
   localparam logic [31:0]       CRC_INIT    = 32'hFFFFFFFF;
   localparam logic [31:0]       CRC_XOROUT  = 32'hFFFFFFFF;
   localparam logic [ADDR_W:0]   CRC_MIN_SPAN = 26'h0000002;

   // Overlay offsets of the two result halves.
   localparam logic [ADDR_W-1:0] OVL_RES_LO = 25'h0000000;
   localparam logic [ADDR_W-1:0] OVL_RES_HI = 25'h0000001;

   // Bit positions in the status word and the error status.
   localparam int SW_CRC_ABORT = 3;
   localparam int SW_PROG_FAIL = 4;
   localparam int SW_READY     = 7;
   localparam int SW_CRC_SUSP  = 8;
   localparam int ES_CORR      = 0;
   localparam int ES_UNCORR    = 1;

   localparam logic [15:0] RESULT_RST = 16'h0000;

   typedef enum logic [1:0] {
      CRC_IDLE = 2'b00,
      CRC_REQ  = 2'b01,
      CRC_WAIT = 2'b10,
      CRC_SUSP = 2'b11
   } fce_crc_state_t;

   // Code position of data bit idx: powers of two are left to check bits.
   function automatic logic [SYN_W-1:0] fce_code_pos(input int idx);
      int               n;
      logic [SYN_W-1:0] r;
      n = 0;
      r = '0;
      for (int p = 1; p < 256; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == idx) r = SYN_W'(p);
            n++;
         end
      end
      return r;
   endfunction

endpackage
`default_nettype wire

/* fce_hamming.sv */
// Hamming code over one 128-bit half-page: encodes, or checks and corrects.
// Assumes the overall parity bit sits in the top bit of the check field.
`default_nettype none

module fce_hamming (
   input  wire logic [fce_pkg::HP_BITS-1:0] data,
   input  wire logic [fce_pkg::CHK_W-1:0]   check_in,
   input  wire logic                        ded_en,
   input  wire logic                        fix_en,
   output logic      [fce_pkg::CHK_W-1:0]   check_out,
   output logic      [fce_pkg::HP_BITS-1:0] data_fix,
   output logic                             single_err,
   output logic                             double_err
);

   logic [fce_pkg::SYN_W-1:0] term [fce_pkg::HP_BITS];
   logic [fce_pkg::SYN_W-1:0] acc;
   logic [fce_pkg::SYN_W-1:0] syn;
   logic                      perr;

   for (genvar i = 0; i < fce_pkg::HP_BITS; i++) begin : g_bit
      localparam logic [fce_pkg::SYN_W-1:0] POS = fce_pkg::fce_code_pos(i);
      assign term[i] = data[i] ? POS : '0;
      assign data_fix[i] = data[i] ^ (fix_en && single_err && syn == POS);
   end

   always_comb begin
      acc = '0;
      for (int i = 0; i < fce_pkg::HP_BITS; i++) acc = acc ^ term[i];
   end

   assign check_out = {(^data) ^ (^acc), acc};
   assign syn       = acc ^ check_in[fce_pkg::SYN_W-1:0];
   assign perr      = (^data) ^ (^check_in);

   // Without the double-error mode the parity bit is ignored, so any
   // nonzero syndrome is taken as one flipped bit.
   always_comb begin
      if (ded_en) begin
         single_err = perr;
         double_err = !perr && syn != '0;
      end else begin
         single_err = syn != '0;
         double_err = 1'b0;
      end
   end

endmodule // fce_hamming
`default_nettype wire

/* fce_crc_word.sv */
// One CRC-32C step over a 16-bit array word, low byte first, MSB first.
// Assumes the caller keeps the running value in a register.
`default_nettype none

module fce_crc_word (
   input  wire logic [31:0] crc_in,
   input  wire logic [15:0] word,
   output logic      [31:0] crc_out
);

   always_comb begin
      logic [15:0] bits;
      logic        fb;
      bits = {word[7:0], word[15:8]};
      fb = 1'b0;
      crc_out = crc_in;
      for (int i = 15; i >= 0; i--) begin
         fb = crc_out[31] ^ bits[i];
         crc_out = {crc_out[30:0], 1'b0} ^ (fb ? fce_pkg::CRC_POLY : 32'h00000000);
      end
   end

endmodule // fce_crc_word
`default_nettype wire

/* fce_array_model.sv */
// Array model: answers each check-value word request a few edges later.
// Assumes the engine holds the request address until the word arrives.
`default_nettype none
module fce_array_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire logic [24:0] addr,
   output logic             valid,
   output logic      [15:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_q;
   // Between words the data lines toggle on every edge, so a stale word shows on alternate cycles only.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 2'h0;
         valid  <= 1'b0;
         data   <= 16'h0000;
      end else begin
         wait_q <= req ? 2'h2 : wait_q - {1'b0, wait_q != 2'h0};
         valid  <= wait_q == 2'h1;
         data   <= wait_q == 2'h1 ? addr[15:0] ^ 16'hA5C3 : ~data;
      end
   end
endmodule // fce_array_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the flash integrity engine and an array model.
// Assumes a 50 ns clock and inputs driven 5 ns after each rising edge.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst, ded_mode_en, prog_commit, prog_hp_written, arr_prog_en_q, hid_check_we_q;
   logic hid_ecc_off_q, fetch_valid, fetch_ecc_off, rd_word_valid_q, ecc_int_en, strobe_stop_en;
   logic ecc_status_clr, xfer_end, ecc_int_q, read_data_strobe_hold_q, dev_standby, cmd_suspend;
   logic other_aso_active, cmd_aso_enter, cmd_aso_exit, cmd_start_wr, cmd_end_wr, cmd_resume;
   logic status_clr, crc_rd_req_q, crc_rd_valid, ovl_rd, address_space_overlay_q;
   logic [127:0] prog_data, fetch_data;
   logic [8:0]   hid_check_q, fetch_check;
   logic [21:0]  fetch_hp_addr;
   logic [2:0]   fetch_word_sel;
   logic [15:0]  rd_word_q, ecc_count_q, crc_rd_data, ovl_rd_data_q, status_word_q;
   logic [1:0]   ecc_status_q;
   logic [24:0]  ecc_err_addr_q, cmd_wdata, crc_rd_addr_q, ovl_rd_addr;
   int n_errors = 0;
   int num_checks = 0;
   int rows[3][2] = '{'{0, 3}, '{5, 90}, '{7, 127}};
   fce_engine fce_engine_inst (.ref_clk, .rst, .ded_mode_en, .prog_commit, .prog_data,
      .prog_hp_written, .arr_prog_en_q, .hid_check_we_q, .hid_check_q, .hid_ecc_off_q,
      .fetch_valid, .fetch_hp_addr, .fetch_data, .fetch_check, .fetch_ecc_off,
      .fetch_word_sel, .rd_word_valid_q, .rd_word_q, .ecc_int_en, .strobe_stop_en,
      .ecc_status_clr, .xfer_end, .ecc_status_q, .ecc_int_q, .read_data_strobe_hold_q,
      .ecc_err_addr_q, .ecc_count_q, .dev_standby, .other_aso_active, .cmd_aso_enter,
      .cmd_aso_exit, .cmd_start_wr, .cmd_end_wr, .cmd_wdata, .cmd_suspend, .cmd_resume,
      .status_clr, .crc_rd_req_q, .crc_rd_addr_q, .crc_rd_valid, .crc_rd_data, .ovl_rd,
      .ovl_rd_addr, .ovl_rd_data_q, .address_space_overlay_q, .status_word_q);
   fce_array_model fce_array_model_inst (.ref_clk, .rst, .req(crc_rd_req_q),
      .addr(crc_rd_addr_q), .valid(crc_rd_valid), .data(crc_rd_data));
   task automatic tick();
      @(posedge ref_clk);
      #5;
   endtask
   // Raise for one edge; one-cycle outputs are looked at right after it.
   task automatic hit(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask
   // Raise for one edge, then give the design one more edge to answer.
   task automatic pulse(ref logic s);
      hit(s);
      tick();
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Words ascend, low byte first, each byte MSB first, as the array model serves them.
   function automatic logic [31:0] crc_exp(input logic [24:0] a, input logic [24:0] b);
      logic [31:0] c;
      logic [15:0] w;
      c = fce_pkg::CRC_INIT;
      for (logic [24:0] i = a; i <= b; i++) begin
         w = i[15:0] ^ 16'hA5C3;
         for (int k = 0; k < 16; k++)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[k < 8 ? 7 - k : 23 - k]) ? fce_pkg::CRC_POLY : 0);
      end
      return c ^ fce_pkg::CRC_XOROUT;
   endfunction
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      {ded_mode_en, prog_commit, prog_hp_written, fetch_valid, fetch_ecc_off, ecc_int_en,
       strobe_stop_en, ecc_status_clr, xfer_end, other_aso_active, cmd_aso_enter, cmd_aso_exit,
       cmd_start_wr, cmd_end_wr, cmd_suspend, cmd_resume, status_clr, ovl_rd, fetch_data,
       fetch_check, fetch_hp_addr, fetch_word_sel, cmd_wdata, ovl_rd_addr} = '0;
      prog_data = 128'h0123456789ABCDEFFEDCBA9876543210;
      rst = 1'b1;
      dev_standby = 1'b1;
      repeat (20) @(posedge ref_clk);
      #5 rst = 1'b0;
      tick();
      check("status after reset", 32'h0080, status_word_q);
      hit(prog_commit);
      check("hidden check write", 32'h3, {arr_prog_en_q, hid_check_we_q});
      fetch_check = hid_check_q;
      ecc_int_en = 1'b1;
      for (int r = 0; r < 3; r++) begin
         fetch_hp_addr = 22'(r);
         fetch_word_sel = 3'(rows[r][0]);
         fetch_data = prog_data ^ (128'h1 << rows[r][1]);
         pulse(fetch_valid);
         check("word", prog_data[16*rows[r][0] +: 16], rd_word_q);
         check("count", r + 1, ecc_count_q);
         check("address", {fetch_hp_addr, fetch_word_sel}, ecc_err_addr_q);
         check("ecc status", 32'h5, {ecc_int_q, ecc_status_q});
      end
      $display("test fetch rows done");
      ded_mode_en = 1'b1;
      prog_hp_written = 1'b1;
      hit(prog_commit);
      check("refused program", 0, {arr_prog_en_q, hid_check_we_q});
      tick();
      check("program fail", 32'h0090, status_word_q);
      pulse(status_clr);
      ded_mode_en = 1'b0;
      hit(prog_commit);
      check("reprogram unprotected", 32'h3, {hid_check_we_q, hid_ecc_off_q});
      {ded_mode_en, strobe_stop_en} = 2'b11;
      fetch_data = prog_data ^ 128'h11;
      hit(fetch_valid);
      check("word valid", 1, rd_word_valid_q);
      check("strobe hold", 1, read_data_strobe_hold_q);
      check("ecc status", 32'h7, {ecc_int_q, ecc_status_q});
      check("count", 4, ecc_count_q);
      pulse(xfer_end);
      check("hold released", 0, read_data_strobe_hold_q);
      {ded_mode_en, strobe_stop_en} = 2'b00;
      $display("test refusal done");
      pulse(cmd_aso_enter);
      cmd_wdata = 25'h0000004;
      pulse(cmd_start_wr);
      cmd_wdata = 25'h0000006;
      // The second run is suspended after its first word and then resumed.
      for (int s = 0; s < 2; s++) begin
         pulse(cmd_end_wr);
         if (s == 1) pulse(cmd_suspend);
         else tick();
         check("busy", 0, status_word_q[7]);
         if (s == 1) begin
            for (int i = 0; i < 20 && status_word_q[8] !== 1'b1; i++) tick();
            check("suspended", 1, status_word_q[8]);
            pulse(cmd_resume);
         end
         for (int i = 0; i < 200 && status_word_q[7] !== 1'b1; i++) tick();
         check("ready", 1, status_word_q[7]);
         for (int h = 0; h < 2; h++) begin
            ovl_rd_addr = 25'(h);
            hit(ovl_rd);
            check("result", crc_exp(25'h4, 25'h6) >> (16 * h) & 32'hFFFF,
                  ovl_rd_data_q);
            tick();
         end
      end
      for (int k = 0; k < 2; k++) begin
         {other_aso_active, dev_standby} = k ? 2'b11 : 2'b00;
         pulse(cmd_end_wr);
         check("start refused", 32'h0080, status_word_q);
      end
      {other_aso_active, dev_standby} = 2'b01;
      cmd_wdata = 25'h0000008;
      pulse(cmd_start_wr);
      cmd_wdata = 25'h0000009;
      pulse(cmd_end_wr);
      tick();
      check("abort", 32'h0088, status_word_q);
      pulse(cmd_aso_exit);
      check("overlay left", 0, address_space_overlay_q);
      $display("test check-value done");
      summarize();
   end
endmodule // testbench
`default_nettype wire
